// ==== can_quirks_pkg.sv ====
/*
  Package for the CAN message-box quirk block: register offsets, field
  positions, reset values, timing constants and the carrier structs.
  Assumes a single 125 MHz system clock and an 8-bit register map reached
  over Avalon-MM, one register per aligned 32-bit word.
*/
// Notes on behaviour
// - While box 15 is valid, writes to its arbitration and data bytes land but reads give junk.
// - While box 15 is not valid, reads of its arbitration and data bytes return what was written.
// - A CAN event on a box with its enables set raises interrupt pending and the interrupt line.
// - A host write that sets interrupt pending by itself raises no interrupt.
// - A valid receive box with control one all reset that matches a remote frame raises receive-OK.
// - In that remote match case a receive interrupt is raised when the receive enable is set.
// - In that remote match case the device also sends its own remote frame besides acknowledging.
// - With the sample-mode bit set, the acknowledge bit goes out one time quantum late.
// - A chip select near the oscillator edge may lose the acknowledge strobe, never the data.
// - Chip select is captured on the rising edge for divide-by-one, falling for divide-by-two.
package can_quirks_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] CPU_CLOCK_DIVIDER_CONFIG_IDX = 8'h02;
  localparam logic [7:0] BIT_TIMING_ONE_IDX           = 8'h4F;
  localparam logic [7:0] BOX15_CONTROL_ZERO_IDX       = 8'hF0;
  localparam logic [7:0] BOX15_CONTROL_ONE_IDX        = 8'hF1;
  localparam logic [7:0] BOX15_ARBITRATION_0_IDX      = 8'hF2;
  localparam logic [7:0] BOX15_ARBITRATION_3_IDX      = 8'hF5;
  localparam logic [7:0] BOX15_CONFIG_IDX             = 8'hF6;
  localparam logic [7:0] BOX15_DATA_0_IDX             = 8'hF7;
  localparam logic [7:0] BOX15_DATA_7_IDX             = 8'hFE;
  localparam logic [7:0] EVENT_STATUS_IDX             = 8'hE0;
  localparam logic [7:0] EVENT_MASK_IDX               = 8'hE1;

  // Field positions
  localparam int OBJECT_VALID_HI          = 7;
  localparam int OBJECT_VALID_LO          = 6;
  localparam int INTERRUPT_PENDING_HI     = 1;
  localparam int INTERRUPT_PENDING_LO     = 0;
  localparam int RECEIVE_INT_ENABLE_HI    = 3;
  localparam int RECEIVE_INT_ENABLE_LO    = 2;
  localparam int SAMPLE_MODE_SELECT_BIT   = 7;
  localparam int DIRECTION_BIT            = 3;
  localparam int DIVIDE_SELECT_BIT        = 6;

  // Two-bit field codes
  localparam logic [1:0] FIELD_RESET = 2'h1;
  localparam logic [1:0] FIELD_SET   = 2'h2;

  // Reset values
  localparam logic [7:0] CONTROL_ZERO_RESET = 8'h55;
  localparam logic [7:0] CONTROL_ONE_RESET  = 8'h55;
  localparam logic [7:0] BYTE_RESET         = 8'h00;
  localparam logic [7:0] UNDEFINED_READ     = 8'hA5;

  // Event status bits
  localparam int EV_BOX_INTERRUPT = 0;
  localparam int EV_RECEIVE_OK    = 1;
  localparam int EV_REMOTE_SENT   = 2;
  localparam int EV_ACK_LOST      = 3;
  localparam int EV_BITS          = 4;

  // Timing: one time quantum in ns and its cycle count at 125 MHz
  localparam int CLK_PERIOD_NS     = 8;
  localparam int TIME_QUANTUM_NS   = 80;
  localparam int QUANTUM_CYCLES    = (TIME_QUANTUM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Event from the CAN protocol engine
  typedef struct packed {
    logic       msg_event;     // Message stored or sent on box 15
    logic       remote_frame;  // Remote frame seen
    logic       id_match;      // Identifier matched box 15
    logic [3:0] length_code;   // Received length code
  } can_event_t;

  // Avalon-MM request
  typedef struct packed {
    logic        read;
    logic        write;
    logic [9:0]  address;
    logic [31:0] writedata;
  } avalon_req_t;

endpackage

// ==== can_message_box_quirks.sv ====
/*
  CAN message-box quirk block: box 15 registers, its interrupt pending
  logic, remote-frame reply, acknowledge timing in majority-sample mode and
  the oscillator-edge chip-select capture with its acknowledge strobe.
  Assumes a CAN protocol engine on the same clock that reports events and
  honours the requests driven here, and an Avalon-MM master for software.
*/
`timescale 1ns/1ps
module can_message_box_quirks
  import can_quirks_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // CAN engine side
  input  wire logic        can_event_in,
  input  wire logic        can_remote_in,
  input  wire logic        can_match_in,
  input  wire logic [3:0]  can_length_in,
  input  wire logic        can_ack_slot_in,
  output logic             remote_tx_request_out,
  output logic             ack_drive_out,
  // Legacy processor pins
  input  wire logic        oscillator_input,
  input  wire logic        chip_select_n_in,
  output logic             bus_acknowledge_strobe_n_out,
  // Interrupt
  output logic             irq_out
);

  typedef enum logic [1:0] {ACK_IDLE = 2'b00, ACK_WAIT = 2'b01, ACK_DRIVE = 2'b11} ack_state_t;

  typedef struct packed {
    logic [7:0]      clk_div;
    logic [7:0]      timing_one;
    logic [7:0]      control_zero;
    logic [7:0]      control_one;
    logic [7:0]      config_byte;
    logic [11:0][7:0] box_bytes;
    logic [EV_BITS-1:0] ev_status;
    logic [EV_BITS-1:0] ev_mask;
    logic [31:0]     rdata;
    logic            waitreq;
    logic            irq;
    logic            remote_tx;
    ack_state_t      ack_state;
    logic [3:0]      ack_count;
    logic            ack_drive;
    logic [2:0]      osc_sync;
    logic [2:0]      cs_sync;
    logic            osc_prev;
    logic            cs_seen;
    logic            strobe_n;
  } state_t;

  state_t st_reg;
  state_t st_next;

  can_event_t ev;
  avalon_req_t req;
  logic [7:0] idx;
  logic       box_valid;
  logic       box_byte_sel;
  logic [3:0] byte_pos;
  logic       remote_case;
  logic       osc_rise;
  logic       osc_fall;
  logic       capture_edge;
  logic [7:0] wbyte;

  assign ev  = '{msg_event: can_event_in, remote_frame: can_remote_in,
                 id_match: can_match_in, length_code: can_length_in};
  assign req = '{read: avs_read_in, write: avs_write_in,
                 address: avs_address_in, writedata: avs_writedata_in};
  assign idx   = req.address[9:2];
  assign wbyte = req.writedata[7:0];
  assign box_valid = (st_reg.control_zero[OBJECT_VALID_HI:OBJECT_VALID_LO] == FIELD_SET);
  assign box_byte_sel = ((idx >= BOX15_ARBITRATION_0_IDX) && (idx <= BOX15_ARBITRATION_3_IDX))
                     || ((idx >= BOX15_DATA_0_IDX) && (idx <= BOX15_DATA_7_IDX));
  assign byte_pos = (idx <= BOX15_ARBITRATION_3_IDX)
                  ? 4'(idx - BOX15_ARBITRATION_0_IDX)
                  : 4'(idx - BOX15_DATA_0_IDX + 8'h04);
  // Stable stages two and three agree before an edge counts
  assign osc_rise = (st_reg.osc_sync[2:1] == 2'b11) && !st_reg.osc_prev;
  assign osc_fall = (st_reg.osc_sync[2:1] == 2'b00) && st_reg.osc_prev;
  assign capture_edge = st_reg.clk_div[DIVIDE_SELECT_BIT] ? osc_fall : osc_rise;
  assign remote_case = ev.msg_event && ev.remote_frame && ev.id_match && box_valid
                    && !st_reg.config_byte[DIRECTION_BIT]
                    && (st_reg.config_byte[7:4] == ev.length_code)
                    && (st_reg.control_one == CONTROL_ONE_RESET);

  // Next-state logic for the whole block
  always_comb
  begin
    st_next = st_reg;
    st_next.remote_tx = 1'b0;
    st_next.osc_sync = {st_reg.osc_sync[1:0], oscillator_input};
    st_next.cs_sync  = {st_reg.cs_sync[1:0], chip_select_n_in};
    if (st_reg.osc_sync[2] == st_reg.osc_sync[1])
    begin
      st_next.osc_prev = st_reg.osc_sync[2];
    end

    // One-cycle answer: waitrequest drops one cycle after the request rises
    st_next.waitreq = 1'b1;
    if ((req.read || req.write) && st_reg.waitreq)
    begin
      st_next.waitreq = 1'b0;
      st_next.rdata = 32'h0000_0000;
      if (req.read)
      begin
        if (box_byte_sel)
        begin
          st_next.rdata[7:0] = box_valid ? UNDEFINED_READ : st_reg.box_bytes[byte_pos];
        end
        else
        begin
          unique case (idx)
            CPU_CLOCK_DIVIDER_CONFIG_IDX: st_next.rdata[7:0] = st_reg.clk_div;
            BIT_TIMING_ONE_IDX:           st_next.rdata[7:0] = st_reg.timing_one;
            BOX15_CONTROL_ZERO_IDX:       st_next.rdata[7:0] = st_reg.control_zero;
            BOX15_CONTROL_ONE_IDX:        st_next.rdata[7:0] = st_reg.control_one;
            BOX15_CONFIG_IDX:             st_next.rdata[7:0] = st_reg.config_byte;
            EVENT_STATUS_IDX:             st_next.rdata[EV_BITS-1:0] = st_reg.ev_status;
            EVENT_MASK_IDX:               st_next.rdata[EV_BITS-1:0] = st_reg.ev_mask;
            default:                      st_next.rdata = 32'h0000_0000;
          endcase
        end
      end
    end
    else if (!(req.read || req.write))
    begin
      st_next.rdata = 32'h0000_0000;
    end

    // Writes take effect at the edge where waitrequest is sampled low
    if (req.write && !st_reg.waitreq)
    begin
      if (box_byte_sel)
      begin
        st_next.box_bytes[byte_pos] = wbyte;
      end
      else
      begin
        unique case (idx)
          CPU_CLOCK_DIVIDER_CONFIG_IDX: st_next.clk_div = wbyte;
          BIT_TIMING_ONE_IDX:           st_next.timing_one = wbyte;
          // host write only stores the field
          BOX15_CONTROL_ZERO_IDX:       st_next.control_zero = wbyte;
          BOX15_CONTROL_ONE_IDX:        st_next.control_one = wbyte;
          BOX15_CONFIG_IDX:             st_next.config_byte = wbyte;
          EVENT_STATUS_IDX:
            st_next.ev_status = st_reg.ev_status & ~req.writedata[EV_BITS-1:0];
          EVENT_MASK_IDX:               st_next.ev_mask = req.writedata[EV_BITS-1:0];
          default:                      st_next.ev_mask = st_reg.ev_mask;
        endcase
      end
    end

    // CAN event sets pending and flags the interrupt; set wins over clear
    if (ev.msg_event && box_valid
        && (st_reg.control_zero[RECEIVE_INT_ENABLE_HI:RECEIVE_INT_ENABLE_LO] == FIELD_SET))
    begin
      st_next.control_zero[INTERRUPT_PENDING_HI:INTERRUPT_PENDING_LO] = FIELD_SET;
      st_next.ev_status[EV_BOX_INTERRUPT] = 1'b1;
    end
    if (remote_case)
    begin
      st_next.ev_status[EV_RECEIVE_OK] = 1'b1;
      st_next.remote_tx = 1'b1;
      st_next.ev_status[EV_REMOTE_SENT] = 1'b1;
    end

    // acknowledge one quantum late in majority mode
    unique case (st_reg.ack_state)
      ACK_IDLE:
      begin
        st_next.ack_drive = 1'b0;
        if (can_ack_slot_in)
        begin
          if (st_reg.timing_one[SAMPLE_MODE_SELECT_BIT])
          begin
            st_next.ack_state = ACK_WAIT;
            st_next.ack_count = 4'(QUANTUM_CYCLES - 1);
          end
          else
          begin
            st_next.ack_state = ACK_DRIVE;
            st_next.ack_drive = 1'b1;
          end
        end
      end
      ACK_WAIT:
      begin
        if (st_reg.ack_count == 4'h0)
        begin
          st_next.ack_state = ACK_DRIVE;
          st_next.ack_drive = 1'b1;
        end
        else
        begin
          st_next.ack_count = st_reg.ack_count - 4'h1;
        end
      end
      ACK_DRIVE:
      begin
        if (!can_ack_slot_in)
        begin
          st_next.ack_state = ACK_IDLE;
          st_next.ack_drive = 1'b0;
        end
      end
      default:
      begin
        st_next.ack_state = ACK_IDLE;
        st_next.ack_drive = 1'b0;
      end
    endcase

    // strobe only when chip select was stable across the capture edge
    if (st_reg.cs_sync[2] != st_reg.cs_sync[1])
    begin
      st_next.cs_seen = 1'b0;
      st_next.strobe_n = 1'b1;
      if (st_reg.cs_sync[1] == 1'b1)
      begin
        // Built on the next value so a lost strobe wins over a same-cycle clear
        st_next.ev_status[EV_ACK_LOST] = st_next.ev_status[EV_ACK_LOST] | !st_reg.cs_seen;
      end
    end
    else if (!st_reg.cs_sync[2] && capture_edge)
    begin
      st_next.cs_seen = 1'b1;
      st_next.strobe_n = 1'b0;
    end

    st_next.irq = |(st_next.ev_status & st_next.ev_mask);
  end

  // State register
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      st_reg <= '0;
      st_reg.control_zero <= CONTROL_ZERO_RESET;
      st_reg.control_one  <= CONTROL_ONE_RESET;
      st_reg.waitreq      <= 1'b1;
      st_reg.strobe_n     <= 1'b1;
      st_reg.cs_sync      <= 3'b111;
      st_reg.ack_state    <= ACK_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flops
  assign avs_readdata_out             = st_reg.rdata;
  assign avs_waitrequest_out          = st_reg.waitreq;
  assign remote_tx_request_out        = st_reg.remote_tx;
  assign ack_drive_out                = st_reg.ack_drive;
  assign bus_acknowledge_strobe_n_out = st_reg.strobe_n;
  assign irq_out                      = st_reg.irq;

  // Checks
  property p_valid_read_junk;
    @(posedge sys_clk_in) disable iff (reset_in)
    (req.read && st_reg.waitreq && box_byte_sel && box_valid)
      |=> (avs_readdata_out[7:0] == UNDEFINED_READ);
  endproperty
  a_valid_read_junk: assert property (p_valid_read_junk) else $error("junk read missing");

  property p_readback;
    @(posedge sys_clk_in) disable iff (reset_in)
    (req.read && st_reg.waitreq && box_byte_sel && !box_valid)
      |=> (avs_readdata_out[7:0] == $past(st_reg.box_bytes[byte_pos]));
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

  property p_event_irq;
    @(posedge sys_clk_in) disable iff (reset_in)
    (ev.msg_event && box_valid && st_reg.ev_mask[EV_BOX_INTERRUPT]
     && st_reg.control_zero[RECEIVE_INT_ENABLE_HI:RECEIVE_INT_ENABLE_LO] == FIELD_SET) |=> irq_out;
  endproperty
  a_event_irq: assert property (p_event_irq) else $error("event did not raise interrupt");

  property p_host_set_quiet;
    @(posedge sys_clk_in) disable iff (reset_in)
    (req.write && !st_reg.waitreq && idx == BOX15_CONTROL_ZERO_IDX && !ev.msg_event && !irq_out
     && !remote_case && st_reg.cs_sync[2] == st_reg.cs_sync[1]) |=> !irq_out;
  endproperty
  a_host_set_quiet: assert property (p_host_set_quiet) else $error("host set raised irq");

  property p_receive_ok;
    @(posedge sys_clk_in) disable iff (reset_in)
    remote_case |=> st_reg.ev_status[EV_RECEIVE_OK];
  endproperty
  a_receive_ok: assert property (p_receive_ok) else $error("receive ok not flagged");

  property p_remote_tx;
    @(posedge sys_clk_in) disable iff (reset_in)
    remote_case |=> remote_tx_request_out ##1 !remote_tx_request_out [*1];
  endproperty
  a_remote_tx: assert property (p_remote_tx) else $error("remote reply missing");

  property p_ack_late;
    @(posedge sys_clk_in) disable iff (reset_in)
    (st_reg.ack_state == ACK_IDLE && can_ack_slot_in && st_reg.timing_one[SAMPLE_MODE_SELECT_BIT])
      |=> !ack_drive_out [*8] ##1 !ack_drive_out [*2] ##1 ack_drive_out;
  endproperty
  a_ack_late: assert property (p_ack_late) else $error("ack not one quantum late");

  property p_ack_prompt;
    @(posedge sys_clk_in) disable iff (reset_in)
    (st_reg.ack_state == ACK_IDLE && can_ack_slot_in && !st_reg.timing_one[SAMPLE_MODE_SELECT_BIT])
      |=> ack_drive_out;
  endproperty
  a_ack_prompt: assert property (p_ack_prompt) else $error("single sample ack late");

  property p_strobe_edge;
    @(posedge sys_clk_in) disable iff (reset_in)
    $fell(bus_acknowledge_strobe_n_out) |-> $past(capture_edge) && !$past(st_reg.cs_sync[2]);
  endproperty
  a_strobe_edge: assert property (p_strobe_edge) else $error("strobe off capture edge");

endmodule

// ==== can_bus_partner.sv ====
/*
  Far-side model: CAN engine events, acknowledge slots and the oscillator pin.
  Assumes the bench clock and that its tasks are called right after a rising edge.
*/
`timescale 1ns/1ps
module can_bus_partner
  import can_quirks_pkg::*;
(
  // Clock
  input  wire logic       clk_in,
  // Engine and pin drive
  output logic            event_out,
  output logic            remote_out,
  output logic            match_out,
  output logic [3:0]      length_out,
  output logic            ack_slot_out,
  output logic            osc_out,
  // Device requests
  input  wire logic       remote_tx_in,
  input  wire logic       ack_drive_in
);
  int remote_count;

  // Idle engine, oscillator parked low
  initial
  begin
    event_out = 1'b0;
    remote_out = 1'b0;
    match_out = 1'b0;
    length_out = 4'h0;
    ack_slot_out = 1'b0;
    osc_out = 1'b0;
    remote_count = 0;
  end

  // Each own remote frame asked for by the device
  always @(posedge clk_in)
    if (remote_tx_in === 1'b1)
      remote_count++;

  // One frame matching box 15; qualifiers invert afterwards so stale
  // values cannot pass for a match
  // single requester
  task automatic send(input logic rem, input logic [3:0] len);
    @(posedge clk_in);
    event_out <= 1'b1;
    remote_out <= rem;
    match_out <= 1'b1;
    length_out <= len;
    @(posedge clk_in);
    event_out <= 1'b0;
    remote_out <= ~rem;
    match_out <= 1'b0;
    length_out <= ~len;
  endtask

  // Opens an ack slot and counts edges until the device drives dominant
  task automatic ack_wait(output int n);
    n = 0;
    @(posedge clk_in);
    ack_slot_out <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (ack_drive_in !== 1'b1 && n < 40);
    ack_slot_out <= 1'b0;
  endtask

  // Oscillator held still so the bench chooses which edge comes
  task automatic osc_set(input logic v);
    @(posedge clk_in);
    osc_out <= v;
  endtask
endmodule

// ==== tb.sv ====
/*
  Self-checking bench for the CAN message-box quirk block.
  Assumes the partner model drives the engine pins and the oscillator pin.
*/
`timescale 1ns/1ps
module tb;
  import can_quirks_pkg::*;
  typedef struct packed {logic [7:0] idx; logic [7:0] wd; logic [7:0] exp;} row_t;
  logic        sys_clk, reset, avs_read, avs_write, avs_waitrequest;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic        ev, rem, mat, slot, rtx, ack, osc, cs_n, strobe_n, irq;
  logic [3:0]  len;
  int          fail_count, cmp_count;
  row_t        rows [7] = '{'{8'hF2, 8'h5A, 8'h5A}, '{8'hF5, 8'hC3, 8'hC3},
    '{8'hF7, 8'h11, 8'h11}, '{8'hFE, 8'hEE, 8'hEE}, '{8'h4F, 8'h00, 8'h00},
    '{8'h02, 8'h00, 8'h00}, '{8'h30, 8'h77, 8'h00}};

  can_message_box_quirks u_can_message_box_quirks (.sys_clk_in(sys_clk), .reset_in(reset),
    .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
    .avs_writedata_in(avs_writedata), .avs_readdata_out(avs_readdata),
    .avs_waitrequest_out(avs_waitrequest), .can_event_in(ev), .can_remote_in(rem),
    .can_match_in(mat), .can_length_in(len), .can_ack_slot_in(slot),
    .remote_tx_request_out(rtx), .ack_drive_out(ack), .oscillator_input(osc),
    .chip_select_n_in(cs_n), .bus_acknowledge_strobe_n_out(strobe_n), .irq_out(irq));

  can_bus_partner u_can_bus_partner (.clk_in(sys_clk), .event_out(ev), .remote_out(rem),
    .match_out(mat), .length_out(len), .ack_slot_out(slot), .osc_out(osc),
    .remote_tx_in(rtx), .ack_drive_in(ack));

  // 125 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Verdict and end of run, shared with the watchdog
  task stop_test;
    $display("checks %0d failures %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Register values
  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // Single-bit flags
  task automatic check_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // One Avalon access; the request stands until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= {idx, 2'h0};
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, wd};
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
      fail_count++;
  endtask

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask

  // Read and compare the bits under the mask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    check_reg(q & {24'hFFFFFF, m}, {24'h0, exp});
  endtask

  // Watchdog well past the expected few hundred cycles
  initial
  begin
    #100000;
    fail_count++;
    stop_test;
  end

  // Main sequence
  initial
  begin
    int n;
    logic low;
    {avs_read, avs_write, cs_n} = 3'b001;
    avs_address = 10'h000;
    avs_writedata = 32'h0;
    fail_count = 0;
    cmp_count = 0;
    reset = 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    check_flag(irq, 1'b0);
    rd_chk(8'hF0, 8'hFF, 8'h55);
    rd_chk(8'hF1, 8'hFF, 8'h55);
    rd_chk(8'hE0, 8'hFF, 8'h00);
    $display("test reset done");
    foreach (rows[i])
    begin
      wr_reg(rows[i].idx, rows[i].wd);
      rd_chk(rows[i].idx, 8'hFF, rows[i].exp);
    end
    $display("test table done");
    // Writes while valid land but read back the undefined value
    wr_reg(8'hF0, 8'h95);
    wr_reg(8'hF7, 8'h3C);
    rd_chk(8'hF7, 8'hFF, UNDEFINED_READ);
    rd_chk(8'hF2, 8'hFF, UNDEFINED_READ);
    wr_reg(8'hF0, 8'h55);
    rd_chk(8'hF7, 8'hFF, 8'h3C);
    $display("test valid readback done");
    wr_reg(8'hE1, 8'h0F);
    wr_reg(8'hF0, 8'h56);
    repeat (3) @(posedge sys_clk);
    check_flag(irq, 1'b0);
    rd_chk(8'hE0, 8'h01, 8'h00);
    wr_reg(8'hF0, 8'h99);
    u_can_bus_partner.send(1'b0, 4'h4);
    repeat (3) @(posedge sys_clk);
    check_flag(irq, 1'b1);
    rd_chk(8'hE0, 8'h01, 8'h01);
    wr_reg(8'hF0, 8'h99);
    wr_reg(8'hE0, 8'h0F);
    repeat (3) @(posedge sys_clk);
    check_flag(irq, 1'b0);
    $display("test interrupt done");
    // Remote frame on a receive box, then one with the wrong length code
    wr_reg(8'hF6, 8'h40);
    wr_reg(8'hF1, 8'h55);
    u_can_bus_partner.send(1'b1, 4'h4);
    repeat (3) @(posedge sys_clk);
    check_reg(32'(u_can_bus_partner.remote_count), 32'h1);
    check_flag(irq, 1'b1);
    rd_chk(8'hE0, 8'h07, 8'h07);
    wr_reg(8'hE0, 8'h0F);
    u_can_bus_partner.send(1'b1, 4'h5);
    repeat (3) @(posedge sys_clk);
    check_reg(32'(u_can_bus_partner.remote_count), 32'h1);
    rd_chk(8'hE0, 8'h06, 8'h00);
    $display("test remote frame done");
    u_can_bus_partner.ack_wait(n);
    check_reg(32'(n), 32'h2);
    wr_reg(8'h4F, 8'h80);
    u_can_bus_partner.ack_wait(n);
    check_reg(32'(n), 32'(2 + QUANTUM_CYCLES));
    wr_reg(8'h4F, 8'h00);
    $display("test ack timing done");
    // Wrong oscillator edge first, then the one the divide bit selects
    wr_reg(8'hF0, 8'h55);
    for (int d = 0; d < 2; d++)
    begin
      wr_reg(8'h02, d[0] ? 8'h40 : 8'h00);
      u_can_bus_partner.osc_set(~d[0]);
      @(posedge sys_clk);
      cs_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      u_can_bus_partner.osc_set(d[0]);
      low = 1'b0;
      repeat (10) @(posedge sys_clk) low |= (strobe_n === 1'b0);
      check_flag(low, 1'b0);
      u_can_bus_partner.osc_set(~d[0]);
      repeat (10) @(posedge sys_clk) low |= (strobe_n === 1'b0);
      check_flag(low, 1'b1);
      // data access ends on waitrequest, not on the strobe
      rd_chk(8'hF7, 8'hFF, 8'h3C);
      cs_n <= 1'b1;
      repeat (10) @(posedge sys_clk);
      check_flag(strobe_n, 1'b1);
    end
    $display("test chip select done");
    // Chip select with no capture edge: no strobe, data still served
    cs_n <= 1'b0;
    low = 1'b0;
    repeat (10) @(posedge sys_clk) low |= (strobe_n === 1'b0);
    check_flag(low, 1'b0);
    rd_chk(8'hF7, 8'hFF, 8'h3C);
    cs_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd_chk(8'hE0, 8'h08, 8'h08);
    check_flag(irq, 1'b1);
    $display("test lost strobe done");
    // Reset in mid-run clears status, mask and the interrupt
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    check_flag(irq, 1'b0);
    rd_chk(8'hF0, 8'hFF, 8'h55);
    rd_chk(8'hE0, 8'hFF, 8'h00);
    rd_chk(8'hE1, 8'hFF, 8'h00);
    $display("test mid-run reset done");
    stop_test;
  end
endmodule
